// *** shared/cl_flags_pkg.sv ***
package cl_flags_pkg;
   // register map, addresses as printed
   localparam logic [7:0] ADDR_ERROR = 8'h0A;
   localparam logic [7:0] ADDR_STATUS = 8'h0B;
   // error register bit positions
   localparam int BIT_NVM = 7;
   localparam int BIT_WRV = 6;
   localparam int BIT_OVF = 5;
   localparam int BIT_SHORT = 4;
   localparam int BIT_EMPTY = 3;
   localparam int BIT_COLL = 2;
   localparam int BIT_PROT = 1;
   localparam int BIT_INTEG = 0;
   // status register bit positions
   localparam int BIT_CIPHER = 5;
   // collision position register: valid marker above the position field
   localparam int BIT_POS_VALID = 7;
   // frame length limits
   localparam logic [3:0] MIN_FRAME_BITS = 4'h4;
   localparam logic [1:0] MIN_EMD_BYTES = 2'h3;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // link state codes as reported in status bits 2..0
   typedef enum logic [2:0] {
      LS_IDLE = 3'h0,
      LS_TX_WAIT = 3'h1,
      LS_TRANSMIT = 3'h3,
      LS_RX_WAIT = 3'h5,
      LS_WAIT_DATA = 3'h6,
      LS_RECEIVE = 3'h7
   } link_state_type;
   // command kinds started by the command decoder
   typedef enum logic [1:0] {
      CMD_OTHER = 2'h0,
      CMD_RECEIVE = 2'h1,
      CMD_TRANSCEIVE = 2'h2,
      CMD_AUTH = 2'h3
   } cmd_kind_type;
endpackage

// *** rtl/cl_error_status_flags.sv ***
`timescale 1ns/1ps
// Operation
// - set nvm error after failed memory command
// - flag buffer writes in forbidden phases
// - clear write violation at command start, or at flag store in multi-frame receive
// - overflow on full write, drop later writes
// - short frame error under four bits
// - drop short frames, keep decoder, no done
// - clear receive errors at receive phase
// - empty transmit error when buffer empty
// - collision flag, record first position
// - ignore collisions inside end symbol
// - protocol error stops reception
// - protocol error withholds last byte
// - integrity error, reception continues
// - collision also sets integrity optionally
// - cipher bit set by auth, host clears
// - report link state in status bits
// - error summary on selected error flags
module cl_error_status_flags
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   // register port
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // command engine
   input wire logic cmd_start_i,
   input wire cl_flags_pkg::cmd_kind_type cmd_kind_i,
   input wire cl_flags_pkg::link_state_type link_state_i,
   input wire logic multi_frame_receive_i,
   input wire logic err_flags_stored_i,
   input wire logic crc_tx_phase_i,
   input wire logic auth_ok_i,
   input wire logic nvm_done_i,
   input wire logic nvm_fail_i,
   input wire logic tx_needed_i,
   // buffer
   input wire logic host_buf_wr_i,
   input wire logic buf_full_i,
   input wire logic buf_empty_i,
   // receiver events
   input wire logic sof_seen_i,
   input wire logic frame_end_i,
   input wire logic [3:0] frame_bits_i,
   input wire logic [1:0] frame_bytes_i,
   input wire logic emd_suppress_i,
   input wire logic rx_byte_valid_i,
   input wire logic coll_i,
   input wire logic coll_in_eof_i,
   input wire logic [6:0] coll_pos_i,
   input wire logic collision_as_integrity_i,
   input wire logic proto_err_i,
   input wire logic integ_err_i,
   // outputs
   output logic buf_wr_accept_o,
   output logic rx_store_o,
   output logic rx_stop_o,
   output logic receive_done_flag_o,
   output logic receive_decoder_o,
   output logic [7:0] collision_position_reg_o,
   output logic error_summary_flag_o,
   output logic cipher_active_o
);
   wire logic [7:0] err_r;
   logic cipher_r;
   cl_flags_pkg::link_state_type state_r;
   logic rx_clr;
   logic wr_forbidden;
   logic short_frame;
   logic coll_hit;
   logic pos_valid;
   logic wr_err_set;
   logic wrv_clr;
   logic nvm_set;
   logic ovf_set;
   logic empty_set;
   logic integ_set;

   // receive-error clear: receive start, or transceive entering wait-data
   assign rx_clr = (cmd_start_i && cmd_kind_i == cl_flags_pkg::CMD_RECEIVE)
      || (cmd_kind_i == cl_flags_pkg::CMD_TRANSCEIVE
          && link_state_i == cl_flags_pkg::LS_WAIT_DATA
          && state_r != cl_flags_pkg::LS_WAIT_DATA);
   // buffer writes forbidden during crc, rx phases and authentication
   assign wr_forbidden = crc_tx_phase_i
      || link_state_i == cl_flags_pkg::LS_RX_WAIT
      || link_state_i == cl_flags_pkg::LS_WAIT_DATA
      || link_state_i == cl_flags_pkg::LS_RECEIVE
      || cmd_kind_i == cl_flags_pkg::CMD_AUTH;
   assign wr_err_set = host_buf_wr_i && wr_forbidden;
   assign ovf_set = host_buf_wr_i && buf_full_i;
   assign empty_set = tx_needed_i && buf_empty_i;
   // short frame: under four bits, or under three bytes with emd active
   assign short_frame = frame_end_i && sof_seen_i
      && (frame_bits_i < cl_flags_pkg::MIN_FRAME_BITS
          || (emd_suppress_i
              && frame_bytes_i < cl_flags_pkg::MIN_EMD_BYTES));
   assign coll_hit = coll_i && !coll_in_eof_i;
   assign integ_set = integ_err_i
      || (coll_hit && collision_as_integrity_i);

   // failed memory command sets, any finished one clears first
   assign nvm_set = nvm_done_i && nvm_fail_i;
   // multi-frame receive defers the clear until flags reach the buffer
   assign wrv_clr = multi_frame_receive_i ? err_flags_stored_i
      : cmd_start_i;
   // a recorded position is kept until the next receive clear
   assign pos_valid = collision_position_reg_o[cl_flags_pkg::BIT_POS_VALID];

   // each error bit is its own flop so every bit has a single owner;
   // a set in the clearing cycle wins, so no event is lost to a start
   // nvm bit follows the outcome of each finished memory command
   cl_sticky_flag u_cl_sticky_flag_nvm
   (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .set_i(nvm_set),
      .clr_i(nvm_done_i),
      .flag_o(err_r[cl_flags_pkg::BIT_NVM])
   );

   // buffer write in a forbidden phase
   cl_sticky_flag u_cl_sticky_flag_wrv
   (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .set_i(wr_err_set),
      .clr_i(wrv_clr),
      .flag_o(err_r[cl_flags_pkg::BIT_WRV])
   );

   // overflow stays until the next command so later writes drop
   cl_sticky_flag u_cl_sticky_flag_ovf
   (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .set_i(ovf_set),
      .clr_i(cmd_start_i),
      .flag_o(err_r[cl_flags_pkg::BIT_OVF])
   );

   // short frame
   cl_sticky_flag u_cl_sticky_flag_short
   (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .set_i(short_frame),
      .clr_i(rx_clr),
      .flag_o(err_r[cl_flags_pkg::BIT_SHORT])
   );

   // nothing to send
   cl_sticky_flag u_cl_sticky_flag_empty
   (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .set_i(empty_set),
      .clr_i(cmd_start_i),
      .flag_o(err_r[cl_flags_pkg::BIT_EMPTY])
   );

   // collision outside the end symbol
   cl_sticky_flag u_cl_sticky_flag_coll
   (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .set_i(coll_hit),
      .clr_i(rx_clr),
      .flag_o(err_r[cl_flags_pkg::BIT_COLL])
   );

   // protocol error
   cl_sticky_flag u_cl_sticky_flag_prot
   (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .set_i(proto_err_i),
      .clr_i(rx_clr),
      .flag_o(err_r[cl_flags_pkg::BIT_PROT])
   );

   // integrity error, optionally fed by collisions
   cl_sticky_flag u_cl_sticky_flag_integ
   (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .set_i(integ_set),
      .clr_i(rx_clr),
      .flag_o(err_r[cl_flags_pkg::BIT_INTEG])
   );

   // first collision position; later collisions keep the first one
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         collision_position_reg_o <= cl_flags_pkg::ZERO_BYTE;
      end
      // a collision in the clearing cycle is recorded, not lost
      else if (coll_hit && (rx_clr || !pos_valid))
      begin
         collision_position_reg_o <= {1'b1, coll_pos_i};
      end
      else if (rx_clr)
      begin
         collision_position_reg_o <= cl_flags_pkg::ZERO_BYTE;
      end
   end

   // cipher: only authentication sets it, a host write of zero clears it
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         cipher_r <= 1'b0;
      end
      else if (auth_ok_i && cmd_kind_i == cl_flags_pkg::CMD_AUTH)
      begin
         cipher_r <= 1'b1;
      end
      else if (reg_wr_i && reg_addr_i == cl_flags_pkg::ADDR_STATUS
               && !reg_wdata_i[cl_flags_pkg::BIT_CIPHER])
      begin
         cipher_r <= 1'b0;
      end
   end

   // registered copy of the engine state, also used to spot wait-data entry
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         state_r <= cl_flags_pkg::LS_IDLE;
      end
      else
      begin
         state_r <= link_state_i;
      end
   end

   // datapath strobes toward buffer and receiver
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         buf_wr_accept_o <= 1'b0;
         rx_store_o <= 1'b0;
         rx_stop_o <= 1'b0;
         receive_done_flag_o <= 1'b0;
         receive_decoder_o <= 1'b0;
      end
      else
      begin
         // writes are dropped while overflow stands, so contents survive
         buf_wr_accept_o <= host_buf_wr_i && !buf_full_i
            && !err_r[cl_flags_pkg::BIT_OVF];
         rx_store_o <= rx_byte_valid_i && !proto_err_i;
         rx_stop_o <= proto_err_i;
         // integrity errors do not stop the frame
         receive_done_flag_o <= (frame_end_i && !short_frame)
            || proto_err_i;
         // decoder stays armed after a discarded short frame
         if (link_state_i == cl_flags_pkg::LS_WAIT_DATA
             || link_state_i == cl_flags_pkg::LS_RECEIVE)
         begin
            receive_decoder_o <= !proto_err_i
               && !(frame_end_i && !short_frame);
         end
         else
         begin
            receive_decoder_o <= 1'b0;
         end
      end
   end

   // summary flag and cipher copy
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         error_summary_flag_o <= 1'b0;
         cipher_active_o <= 1'b0;
      end
      else
      begin
         error_summary_flag_o <= err_r[cl_flags_pkg::BIT_WRV]
            | err_r[cl_flags_pkg::BIT_OVF] | err_r[cl_flags_pkg::BIT_PROT]
            | err_r[cl_flags_pkg::BIT_EMPTY]
            | err_r[cl_flags_pkg::BIT_INTEG];
         cipher_active_o <= cipher_r;
      end
   end

   // read data registered; reads change nothing
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         reg_rdata_o <= cl_flags_pkg::ZERO_BYTE;
      end
      else
      begin
         case (reg_addr_i)
            cl_flags_pkg::ADDR_ERROR: reg_rdata_o <= err_r;
            cl_flags_pkg::ADDR_STATUS:
               reg_rdata_o <= {2'b00, cipher_r, 2'b00, state_r};
            default: reg_rdata_o <= cl_flags_pkg::ZERO_BYTE;
         endcase
      end
   end
endmodule // cl_error_status_flags

// one sticky flag; a set in the clearing cycle wins so no event is lost
module cl_sticky_flag
#(
   parameter logic RST_VAL = 1'b0
)
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);
   // set has priority over clear
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         flag_o <= RST_VAL;
      end
      else if (set_i)
      begin
         flag_o <= 1'b1;
      end
      else if (clr_i)
      begin
         flag_o <= 1'b0;
      end
   end
endmodule // cl_sticky_flag

// *** sim/cl_flags_asserts.sv ***
`timescale 1ns/1ps
// port-level checks of the flag block
module cl_flags_asserts
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic host_buf_wr_i,
   input wire logic buf_full_i,
   input wire logic proto_err_i,
   input wire logic frame_end_i,
   input wire logic [3:0] frame_bits_i,
   input wire logic sof_seen_i,
   input wire logic auth_ok_i,
   input wire logic [7:0] reg_addr_i,
   input wire cl_flags_pkg::link_state_type link_state_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic buf_wr_accept_o,
   input wire logic rx_stop_o,
   input wire logic rx_store_o,
   input wire logic receive_done_flag_o,
   input wire logic error_summary_flag_o,
   input wire logic cipher_active_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   property p_full;
      host_buf_wr_i && buf_full_i |=> !buf_wr_accept_o;
   endproperty
   a_full: assert property (p_full)
      else $error("full write accepted");
   property p_sum;
      host_buf_wr_i && buf_full_i |-> ##2 error_summary_flag_o;
   endproperty
   a_sum: assert property (p_sum)
      else $error("summary missing");
   property p_stop;
      proto_err_i |=> rx_stop_o;
   endproperty
   a_stop: assert property (p_stop)
      else $error("no stop");
   property p_store;
      proto_err_i |=> !rx_store_o;
   endproperty
   a_store: assert property (p_store)
      else $error("byte stored");
   property p_short;
      frame_end_i && sof_seen_i && !proto_err_i
         && frame_bits_i < cl_flags_pkg::MIN_FRAME_BITS
         |=> !receive_done_flag_o;
   endproperty
   a_short: assert property (p_short)
      else $error("short frame done");
   // only an authentication success may switch the cipher on;
   // two flops stand between the pulse and the output
   property p_cipher;
      $rose(cipher_active_o) |-> $past(auth_ok_i, 2);
   endproperty
   a_cipher: assert property (p_cipher)
      else $error("cipher set");
   // read data lags the address by one edge and the state by two
   property p_stat;
      $past(nrst_i) && $past(nrst_i, 2)
         && $past(reg_addr_i) == cl_flags_pkg::ADDR_STATUS
         |-> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[4:3] == 2'h0
         && reg_rdata_o[2:0] == $past(link_state_i, 2);
   endproperty
   a_stat: assert property (p_stat)
      else $error("status read");
   property p_unmap;
      $past(nrst_i) && $past(reg_addr_i) > 8'h0B |-> reg_rdata_o == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read");
endmodule // cl_flags_asserts

// *** sim/host_reg_model.sv ***
`timescale 1ns/1ps
// host side of the register port, moves on the falling edge
module host_reg_model
(
   input wire logic mclk_i,
   input wire logic [7:0] rdata_i,
   output logic wr_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial
   begin
      wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // one-cycle strobe; data is scrambled after, not left standing
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge mclk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask
   // read data is registered, so it is taken one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk_i);
      addr_o = a;
      @(negedge mclk_i);
      d = rdata_i;
   endtask
endmodule // host_reg_model

// *** sim/cl_error_status_flags_tb.sv ***
`timescale 1ns/1ps
module cl_error_status_flags_tb;
   localparam logic [7:0] EA = cl_flags_pkg::ADDR_ERROR;
   localparam logic [7:0] EB = cl_flags_pkg::ADDR_STATUS;
   logic mclk_i = 1'b0, nrst_i = 1'b0, reg_wr_i, cmd_start_i = 1'b0;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, collision_position_reg_o;
   cl_flags_pkg::cmd_kind_type cmd_kind_i = cl_flags_pkg::CMD_OTHER;
   cl_flags_pkg::link_state_type link_state_i = cl_flags_pkg::LS_IDLE;
   logic multi_frame_receive_i = 1'b0, err_flags_stored_i = 1'b0;
   logic crc_tx_phase_i = 1'b0, auth_ok_i = 1'b0, nvm_done_i = 1'b0;
   logic nvm_fail_i = 1'b0, tx_needed_i = 1'b0, host_buf_wr_i = 1'b0;
   logic buf_full_i = 1'b0, buf_empty_i = 1'b0, sof_seen_i = 1'b0;
   logic frame_end_i = 1'b0, emd_suppress_i = 1'b0, rx_byte_valid_i = 1'b0;
   logic [3:0] frame_bits_i = 4'h0;
   logic [1:0] frame_bytes_i = 2'h0;
   logic [6:0] coll_pos_i = 7'h00;
   logic coll_i = 1'b0, coll_in_eof_i = 1'b0, collision_as_integrity_i = 1'b0;
   logic proto_err_i = 1'b0, integ_err_i = 1'b0, buf_wr_accept_o, rx_store_o;
   logic rx_stop_o, receive_done_flag_o, receive_decoder_o;
   logic error_summary_flag_o, cipher_active_o;
   int n_errors = 0;
   int total_checks = 0;
   cl_error_status_flags u_cl_error_status_flags (.mclk_i, .nrst_i, .reg_wr_i,
      .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .cmd_start_i, .cmd_kind_i,
      .link_state_i, .multi_frame_receive_i, .err_flags_stored_i,
      .crc_tx_phase_i, .auth_ok_i, .nvm_done_i, .nvm_fail_i, .tx_needed_i,
      .host_buf_wr_i, .buf_full_i, .buf_empty_i, .sof_seen_i, .frame_end_i,
      .frame_bits_i, .frame_bytes_i, .emd_suppress_i, .rx_byte_valid_i,
      .coll_i, .coll_in_eof_i, .coll_pos_i, .collision_as_integrity_i,
      .proto_err_i, .integ_err_i, .buf_wr_accept_o, .rx_store_o, .rx_stop_o,
      .receive_done_flag_o, .receive_decoder_o, .collision_position_reg_o,
      .error_summary_flag_o, .cipher_active_o);
   host_reg_model u_host_reg_model (.mclk_i, .rdata_i(reg_rdata_o),
      .wr_o(reg_wr_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
   // 40 MHz
   initial
   begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   task automatic nx();
      @(negedge mclk_i);
   endtask
   task automatic wrap_up();
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
      logic [7:0] d;
      u_host_reg_model.rd(a, d);
      cmp(d & m, e);
   endtask
   task automatic start(input cl_flags_pkg::cmd_kind_type k);
      cmd_kind_i = k;
      cmd_start_i = 1'b1;
      nx();
      cmd_start_i = 1'b0;
   endtask
   // overflow latches and keeps refusing after the buffer drains
   task automatic t_ovf();
      buf_full_i = 1'b1;
      host_buf_wr_i = 1'b1;
      nx();
      host_buf_wr_i = 1'b0;
      buf_full_i = 1'b0;
      nx();
      cmp(error_summary_flag_o, 1'b1);
      chk(EA, 8'h20, 8'h20);
      host_buf_wr_i = 1'b1;
      nx();
      host_buf_wr_i = 1'b0;
      cmp(buf_wr_accept_o, 1'b0);
      start(cl_flags_pkg::CMD_OTHER);
   endtask
   task automatic t_wrv();
      link_state_i = cl_flags_pkg::LS_RX_WAIT;
      host_buf_wr_i = 1'b1;
      nx();
      host_buf_wr_i = 1'b0;
      chk(EA, 8'h40, 8'h40);
      start(cl_flags_pkg::CMD_OTHER);
      chk(EA, 8'h40, 8'h00);
      // multi-frame: command start keeps it, storing the flags clears it
      multi_frame_receive_i = 1'b1;
      host_buf_wr_i = 1'b1;
      nx();
      host_buf_wr_i = 1'b0;
      start(cl_flags_pkg::CMD_OTHER);
      chk(EA, 8'h40, 8'h40);
      err_flags_stored_i = 1'b1;
      nx();
      err_flags_stored_i = 1'b0;
      multi_frame_receive_i = 1'b0;
      chk(EA, 8'h40, 8'h00);
   endtask
   // protocol error beside a byte; clearing waits for wait-data
   task automatic t_rx();
      link_state_i = cl_flags_pkg::LS_RECEIVE;
      rx_byte_valid_i = 1'b1;
      nx();
      cmp(rx_store_o, 1'b1);
      integ_err_i = 1'b1;
      nx();
      integ_err_i = 1'b0;
      proto_err_i = 1'b1;
      nx();
      proto_err_i = 1'b0;
      rx_byte_valid_i = 1'b0;
      cmp(rx_stop_o, 1'b1);
      cmp(rx_store_o, 1'b0);
      chk(EA, 8'h03, 8'h03);
      link_state_i = cl_flags_pkg::LS_TX_WAIT;
      start(cl_flags_pkg::CMD_TRANSCEIVE);
      chk(EA, 8'h03, 8'h03);
      link_state_i = cl_flags_pkg::LS_WAIT_DATA;
      chk(EA, 8'h03, 8'h00);
   endtask
   // 3 data bits is short, 4 is the first good length
   task automatic t_short();
      sof_seen_i = 1'b1;
      frame_bits_i = 4'h3;
      frame_end_i = 1'b1;
      nx();
      frame_end_i = 1'b0;
      cmp(receive_done_flag_o, 1'b0);
      cmp(receive_decoder_o, 1'b1);
      chk(EA, 8'h10, 8'h10);
      frame_bits_i = 4'h4;
      frame_end_i = 1'b1;
      nx();
      frame_end_i = 1'b0;
      cmp(receive_done_flag_o, 1'b1);
      // two bytes with disturbance suppression on is still too short
      emd_suppress_i = 1'b1;
      frame_bytes_i = 2'h2;
      frame_bits_i = 4'h8;
      frame_end_i = 1'b1;
      nx();
      frame_end_i = 1'b0;
      emd_suppress_i = 1'b0;
      cmp(receive_done_flag_o, 1'b0);
      cmp(receive_decoder_o, 1'b1);
   endtask
   task automatic t_coll();
      collision_as_integrity_i = 1'b1;
      start(cl_flags_pkg::CMD_RECEIVE);
      coll_pos_i = 7'h11;
      coll_i = 1'b1;
      nx();
      coll_pos_i = 7'h05;
      nx();
      coll_i = 1'b0;
      cmp(collision_position_reg_o, 8'h91);
      chk(EA, 8'h15, 8'h05);
      collision_as_integrity_i = 1'b0;
      start(cl_flags_pkg::CMD_RECEIVE);
      coll_in_eof_i = 1'b1;
      coll_i = 1'b1;
      nx();
      coll_i = 1'b0;
      cmp(collision_position_reg_o, 8'h00);
      chk(EA, 8'h05, 8'h00);
   endtask
   task automatic t_misc();
      nvm_fail_i = 1'b1;
      nvm_done_i = 1'b1;
      nx();
      nvm_done_i = 1'b0;
      chk(EA, 8'h80, 8'h80);
      buf_empty_i = 1'b1;
      tx_needed_i = 1'b1;
      nx();
      tx_needed_i = 1'b0;
      chk(EA, 8'h08, 8'h08);
      start(cl_flags_pkg::CMD_AUTH);
      auth_ok_i = 1'b1;
      nx();
      auth_ok_i = 1'b0;
      u_host_reg_model.wr(EB, 8'hFF);
      chk(EB, 8'h20, 8'h20);
      cmp(cipher_active_o, 1'b1);
      u_host_reg_model.wr(EB, 8'h00);
      chk(EB, 8'h20, 8'h00);
      cmp(cipher_active_o, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         if (i != 2 && i != 4)
         begin
            link_state_i = cl_flags_pkg::link_state_type'(i[2:0]);
            chk(EB, 8'hFF, {5'h00, i[2:0]});
         end
      end
      chk(8'h0C, 8'hFF, 8'h00);
   endtask
   initial
   begin
      repeat (16) nx();
      nrst_i = 1'b1;
      nx();
      t_ovf();
      t_wrv();
      t_rx();
      t_short();
      t_coll();
      t_misc();
      wrap_up();
   end
   // hang guard
   initial
   begin
      #100us;
      n_errors++;
      wrap_up();
   end
endmodule // cl_error_status_flags_tb
bind cl_error_status_flags cl_flags_asserts u_cl_flags_asserts (.mclk_i,
   .nrst_i, .host_buf_wr_i, .buf_full_i, .proto_err_i, .frame_end_i,
   .frame_bits_i, .sof_seen_i, .auth_ok_i, .reg_addr_i, .link_state_i,
   .reg_rdata_o,
   .buf_wr_accept_o, .rx_stop_o, .rx_store_o, .receive_done_flag_o,
   .error_summary_flag_o, .cipher_active_o);
